/* File: design/ddct_pkg.sv */
`default_nettype none
package ddct_pkg;
  // clock and noise rejector timing
  localparam int CLK_HZ = 20_000_000;
  localparam int FILT_HZ = 2048;
  // one internal sampling falling edge per period, rounded down
  localparam int FILT_CYC = CLK_HZ / FILT_HZ;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PRE = 8'h04;
  localparam logic [7:0] OFS_RLD0 = 8'h08;
  localparam logic [7:0] OFS_RLD1 = 8'h0c;
  localparam logic [7:0] OFS_CNT0 = 8'h10;
  localparam logic [7:0] OFS_CNT1 = 8'h14;
  localparam logic [7:0] OFS_FLAG = 8'h18;
  localparam logic [7:0] OFS_MASK = 8'h1c;
  // control and flag register fields
  localparam int CTRL_W = 14;
  localparam int CB_RUN0 = 0;
  localparam int CB_RUN1 = 1;
  localparam int CB_W16 = 2;
  localparam int CB_EVM = 3;
  localparam int CB_POL = 4;
  localparam int CB_FEN = 5;
  localparam int CB_TSEL = 6;
  localparam int CB_PS0 = 8;
  localparam int CB_CK0 = 12;
  localparam int FB_TOG = 2;
  // values after reset
  localparam logic [CTRL_W-1:0] CTRL_RST = 14'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // prescaler terminal counts for codes 00, 01, 10, 11
  localparam logic [3:0][7:0] PS_TC = {8'hff, 8'h1f, 8'h03, 8'h00};
endpackage
`default_nettype wire

/* File: design/ddct_timer.sv */
// Summary of operation
// R1: two 8-bit down counters, each with its own 8-bit reload value.
// R2: width mode 0 runs both timers separately with their own controls.
// R3: preload strobe 1 copies the reload value into the counter.
// R4: run control 1 lets the count clock decrement; 0 halts it.
// R5: stop and restart keep the count; counting resumes from it.
// R6: reading the low count freezes the high count; read low first.
// R7: on underflow the counter reloads and keeps counting.
// R8: underflow drives interrupt request, toggle output, and timer 1 serial clock.
// R9: counter mode 0 makes timer 0 count the prescaler; reset selects it.
// R10: timer 1 never counts the event input.
// R11: counter mode 1 makes timer 0 count event input edges.
// R12: event mode ignores timer 0 prescale ratio and source select.
// R13: polarity 0 counts falling edges, 1 counts rising edges.
// R14: noise filter enable inserts a rejector before the event input.
// R15: rejector accepts a change at the second 2048 Hz falling edge.
// R16: the pulse source holds each level at least 0.98 ms.
// R17: prescale codes 00..11 divide by 1, 4, 32, 256.
// R18: source select 0 picks low-speed, 1 high-speed oscillator.
// R19: underflow sets the flag always; request only while mask enables.
// R20: toggle output flips on each underflow of the selected timer.
// R21: event input is synchronised before edge detection, one decrement each.
//
// The AHB-Lite slave port and the address map were decided locally.
`default_nettype none
module ddct_timer #(
  parameter int FILT_CYCLES = ddct_pkg::FILT_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic lowSpeedOsc,
  input wire logic highSpeedOsc,
  input wire logic eventInputPin,
  output logic underflowToggleOutput,
  output logic serialClkOut,
  output logic irqReqT0,
  output logic irqReqT1
);

  typedef struct packed {
    logic [ddct_pkg::CTRL_W-1:0] ctrl;
    logic [1:0][7:0] rld;
    logic [1:0][7:0] cnt;
    logic [1:0][7:0] ps;
    logic [7:0] hold;
    logic [1:0] flag;
    logic [1:0] mask;
    logic tog;
    logic ser;
    logic [2:0][3:0] pin;
    logic fLvl;
    logic evPrev;
    logic [1:0] fCnt;
    logic [13:0] fDiv;
    logic dWr;
    logic rdPend;
    logic [7:0] dAddr;
    logic [31:0] rdata;
  } ddct_st_t;

  ddct_st_t st_r;
  ddct_st_t st_nxt;

  logic [2:0] rawPin;
  logic [2:0] acc;
  logic [1:0] oscRise;
  logic [1:0] pre;
  logic [1:0] run;
  logic [1:0] psOut;
  logic [1:0] tk;
  logic [1:0] uf;
  logic [1:0] code;
  logic chain;
  logic evMode;
  logic evSrc;
  logic evEdge;
  logic evTick;
  logic fTick;
  logic ufSel;
  logic addrPhase;

  assign rawPin = {eventInputPin, highSpeedOsc, lowSpeedOsc};

  always_comb begin
    st_nxt = st_r;
    code = 2'b00;
    // bus: zero-wait writes, one wait state on reads so a read just
    // after a write sees the written value
    addrPhase = hsel && htrans[1] && hready;
    st_nxt.dWr = addrPhase && hwrite;
    st_nxt.rdPend = addrPhase && !hwrite;
    if (addrPhase) begin
      st_nxt.dAddr = haddr[7:0];
    end
    // three-stage pin synchronisers; a level is taken once stages 2 and 3
    // agree, stage 1 feeds only stage 2
    for (int k = 0; k < 3; k++) begin
      acc[k] = st_r.pin[k][3];
      st_nxt.pin[k][0] = rawPin[k];
      st_nxt.pin[k][1] = st_r.pin[k][0];
      st_nxt.pin[k][2] = st_r.pin[k][1];
      if (st_r.pin[k][1] == st_r.pin[k][2]) begin
        st_nxt.pin[k][3] = st_r.pin[k][2];
      end
    end
    for (int k = 0; k < 2; k++) begin
      oscRise[k] = (st_r.pin[k][1] == st_r.pin[k][2]) &&
                   st_r.pin[k][2] && !st_r.pin[k][3];
    end
    // internal 2048 Hz falling-edge tick
    fTick = (st_r.fDiv == 14'(FILT_CYCLES - 1));
    st_nxt.fDiv = fTick ? 14'h0000 : st_r.fDiv + 14'h0001; // R15
    // noise rejector: a changed level must survive two sampling edges
    if (!st_r.ctrl[ddct_pkg::CB_FEN]) begin
      st_nxt.fLvl = acc[2];
      st_nxt.fCnt = 2'b00;
    end else if (acc[2] == st_r.fLvl) begin
      st_nxt.fCnt = 2'b00; // R14
    end else if (fTick) begin
      if (st_r.fCnt == 2'b01) begin
        st_nxt.fLvl = acc[2]; // R15
        st_nxt.fCnt = 2'b00;
      end else begin
        st_nxt.fCnt = st_r.fCnt + 2'b01;
      end
    end
    evSrc = st_r.fLvl;
    st_nxt.evPrev = evSrc;
    evEdge = (evSrc != st_r.evPrev); // R21
    chain = st_r.ctrl[ddct_pkg::CB_W16];
    evMode = st_r.ctrl[ddct_pkg::CB_EVM];
    evTick = evEdge && (evSrc == st_r.ctrl[ddct_pkg::CB_POL]); // R13
    // in chained mode timer 0's run bit steers both halves
    run[0] = st_r.ctrl[ddct_pkg::CB_RUN0]; // R4
    run[1] = chain ? st_r.ctrl[ddct_pkg::CB_RUN0]
                   : st_r.ctrl[ddct_pkg::CB_RUN1]; // R2
    for (int i = 0; i < 2; i++) begin
      pre[i] = st_r.dWr && (st_r.dAddr == ddct_pkg::OFS_PRE) && hwdata[i];
      code = st_r.ctrl[ddct_pkg::CB_PS0 + 2 * i +: 2];
      psOut[i] = 1'b0;
      // prescaler only runs while its timer runs
      if (!run[i]) begin
        st_nxt.ps[i] = 8'h00;
      end else if (oscRise[st_r.ctrl[ddct_pkg::CB_CK0 + i]]) begin // R18
        if (st_r.ps[i] == ddct_pkg::PS_TC[code]) begin // R17
          st_nxt.ps[i] = 8'h00;
          psOut[i] = 1'b1;
        end else begin
          st_nxt.ps[i] = st_r.ps[i] + 8'h01;
        end
      end
      if (i == 0) begin
        tk[0] = run[0] && (evMode ? evTick : psOut[0]); // R9 R11 R12
      end else begin
        tk[1] = run[1] && (chain ? uf[0] : psOut[1]); // R10
      end
      uf[i] = 1'b0;
      if (pre[i]) begin
        st_nxt.cnt[i] = st_r.rld[i]; // R3
      end else if (tk[i]) begin
        if (st_r.cnt[i] == 8'h00) begin
          uf[i] = 1'b1;
          st_nxt.cnt[i] = st_r.rld[i]; // R7
        end else begin
          st_nxt.cnt[i] = st_r.cnt[i] - 8'h01; // R1 R5
        end
      end
    end
    ufSel = st_r.ctrl[ddct_pkg::CB_TSEL] ? uf[1] : uf[0];
    if (ufSel) begin
      st_nxt.tog = !st_r.tog; // R20
    end
    if (uf[1]) begin
      st_nxt.ser = !st_r.ser; // R8
    end
    // register writes; a set in the clearing cycle wins
    st_nxt.flag = st_r.flag | uf; // R19
    if (st_r.dWr) begin
      unique case (st_r.dAddr)
        ddct_pkg::OFS_CTRL: st_nxt.ctrl = hwdata[ddct_pkg::CTRL_W-1:0];
        ddct_pkg::OFS_RLD0: st_nxt.rld[0] = hwdata[7:0];
        ddct_pkg::OFS_RLD1: st_nxt.rld[1] = hwdata[7:0];
        ddct_pkg::OFS_FLAG: st_nxt.flag = (st_r.flag & ~hwdata[1:0]) | uf;
        ddct_pkg::OFS_MASK: st_nxt.mask = hwdata[1:0];
        default: st_nxt.rdata = st_r.rdata;
      endcase
    end
    // read capture; low count read freezes the high count
    if (st_r.rdPend) begin
      unique case (st_r.dAddr)
        ddct_pkg::OFS_CTRL: st_nxt.rdata = {18'h00000, st_r.ctrl};
        ddct_pkg::OFS_RLD0: st_nxt.rdata = {24'h000000, st_r.rld[0]};
        ddct_pkg::OFS_RLD1: st_nxt.rdata = {24'h000000, st_r.rld[1]};
        ddct_pkg::OFS_CNT0: begin
          st_nxt.rdata = {24'h000000, st_r.cnt[0]};
          st_nxt.hold = st_r.cnt[1]; // R6
        end
        ddct_pkg::OFS_CNT1: st_nxt.rdata = {24'h000000, st_r.hold};
        ddct_pkg::OFS_FLAG: st_nxt.rdata = {29'h0, st_r.tog, st_r.flag};
        ddct_pkg::OFS_MASK: st_nxt.rdata = {30'h0, st_r.mask};
        default: st_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.ctrl <= ddct_pkg::CTRL_RST;
      st_r.rld <= {ddct_pkg::BYTE_RST, ddct_pkg::BYTE_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata = st_r.rdata;
  assign hreadyout = !st_r.rdPend;
  assign hresp = 1'b0;
  assign underflowToggleOutput = st_r.tog; // R8
  assign serialClkOut = st_r.ser;
  assign irqReqT0 = st_r.flag[0] && st_r.mask[0]; // R19
  assign irqReqT1 = st_r.flag[1] && st_r.mask[1];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  preload_load_a: assert property ( // R3
    pre[0] |=> st_r.cnt[0] == $past(st_r.rld[0]))
    else $error("preload did not copy reload value");
  stop_hold_a: assert property ( // R5
    !st_r.ctrl[ddct_pkg::CB_RUN0] && !pre[0] |=> $stable(st_r.cnt[0]))
    else $error("stopped counter changed");
  run_dec_a: assert property ( // R4
    tk[0] && !pre[0] && st_r.cnt[0] != 8'h00
    |=> st_r.cnt[0] == $past(st_r.cnt[0]) - 8'h01)
    else $error("running counter did not decrement");
  uf_reload_a: assert property ( // R7
    uf[1] && !pre[1] |=> st_r.cnt[1] == $past(st_r.rld[1]))
    else $error("underflow did not reload");
  flag_set_a: assert property ( // R19
    uf[0] |=> st_r.flag[0] && irqReqT0 == st_r.mask[0])
    else $error("underflow flag not set");
  toggle_flip_a: assert property ( // R20
    ufSel |=> underflowToggleOutput != $past(underflowToggleOutput))
    else $error("toggle output did not flip");
  t1_source_a: assert property ( // R10
    !chain && !psOut[1] && !pre[1] |=> $stable(st_r.cnt[1]))
    else $error("timer 1 ticked from a wrong source");
  edge_pol_a: assert property ( // R13
    evMode && evEdge && evSrc != st_r.ctrl[ddct_pkg::CB_POL] |-> !tk[0])
    else $error("wrong edge counted");
  ps_ignored_a: assert property ( // R12
    evMode && !evEdge |-> !tk[0])
    else $error("prescaler ticked timer 0 in event mode");
  hold_latch_a: assert property ( // R6
    st_r.rdPend && st_r.dAddr == ddct_pkg::OFS_CNT0
    |=> st_r.hold == $past(st_r.cnt[1]))
    else $error("high count not frozen");
  filt_edge_a: assert property ( // R15
    st_r.ctrl[ddct_pkg::CB_FEN] && $past(st_r.ctrl[ddct_pkg::CB_FEN])
    && $changed(st_r.fLvl)
    |-> $past(fTick) && $past(st_r.fCnt) == 2'b01)
    else $error("rejector passed a change early");
  read_wait_a: assert property (
    addrPhase && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read answer timing wrong");

  // the rejector only owns the level once it has been on for a cycle;
  // the enabling write itself may still pass a tracked change
  preload_t1_a: assert property ( // R3
    pre[1] |=> st_r.cnt[1] == $past(st_r.rld[1]))
    else $error("timer 1 preload did not copy reload value");
  t0_reload_a: assert property ( // R7
    uf[0] |=> st_r.cnt[0] == $past(st_r.rld[0]))
    else $error("timer 0 underflow did not reload");
  uf_zero_a: assert property ( // R7
    uf[0] |-> st_r.cnt[0] == 8'h00 && tk[0])
    else $error("underflow without a tick at zero");
  t1_dec_a: assert property ( // R4
    tk[1] && !pre[1] && st_r.cnt[1] != 8'h00
    |=> st_r.cnt[1] == $past(st_r.cnt[1]) - 8'h01)
    else $error("timer 1 did not decrement");
  t1_stop_a: assert property ( // R5
    !run[1] && !pre[1] |=> $stable(st_r.cnt[1]))
    else $error("stopped timer 1 changed");
  chain_run_a: assert property ( // R1
    chain |-> run[1] == run[0])
    else $error("chained halves run apart");
  ser_flip_a: assert property ( // R8
    uf[1] |=> serialClkOut != $past(serialClkOut))
    else $error("serial clock did not flip");
  ser_keep_a: assert property ( // R8
    !uf[1] |=> $stable(serialClkOut))
    else $error("serial clock flipped without underflow");
  tog_keep_a: assert property ( // R20
    !ufSel |=> $stable(underflowToggleOutput))
    else $error("toggle output flipped without underflow");
  flag1_set_a: assert property ( // R19
    uf[1] |=> st_r.flag[1] && irqReqT1 == st_r.mask[1])
    else $error("timer 1 underflow flag not set");
  flag_clear_a: assert property ( // R19
    st_r.dWr && st_r.dAddr == ddct_pkg::OFS_FLAG && hwdata[0] && !uf[0]
    |=> !st_r.flag[0])
    else $error("flag not cleared by writing one");
  irq0_mask_a: assert property ( // R19
    !st_r.mask[0] |-> !irqReqT0)
    else $error("masked timer 0 request raised");
  irq1_mask_a: assert property ( // R19
    !st_r.mask[1] |-> !irqReqT1)
    else $error("masked timer 1 request raised");
  timer_mode_a: assert property ( // R9
    !evMode && !psOut[0] && !pre[0] |=> $stable(st_r.cnt[0]))
    else $error("timer mode counted without prescaler output");
  ev_count_a: assert property ( // R11
    evMode && run[0] && evTick && !pre[0] && st_r.cnt[0] != 8'h00
    |=> st_r.cnt[0] == $past(st_r.cnt[0]) - 8'h01)
    else $error("event edge not counted");
  filt_off_a: assert property ( // R14
    !st_r.ctrl[ddct_pkg::CB_FEN] |=> st_r.fLvl == $past(acc[2]))
    else $error("event level delayed with rejector off");
  fdiv_wrap_a: assert property ( // R15
    fTick |=> st_r.fDiv == 14'h0000)
    else $error("sampling divider did not wrap");
  sync_hold_a: assert property ( // R21
    st_r.pin[2][1] != st_r.pin[2][2] |=> $stable(st_r.pin[2][3]))
    else $error("event level taken before stages agreed");
  ps_div_a: assert property ( // R17
    psOut[0]
    |-> st_r.ps[0] == ddct_pkg::PS_TC[st_r.ctrl[ddct_pkg::CB_PS0 +: 2]])
    else $error("prescaler ended at a wrong count");
  src_sel_a: assert property ( // R18
    run[0] && !st_r.ctrl[ddct_pkg::CB_CK0] && !oscRise[0] |-> !psOut[0])
    else $error("prescaler stepped without selected source");
  hold_keep_a: assert property ( // R6
    !(st_r.rdPend && st_r.dAddr == ddct_pkg::OFS_CNT0)
    |=> $stable(st_r.hold))
    else $error("held high count changed without low read");
  write_ready_a: assert property (
    addrPhase && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  read_hold_a: assert property (
    !st_r.rdPend |=> $stable(hrdata))
    else $error("read data changed outside a capture");

endmodule
`default_nettype wire

/* File: testbench/ddct_pulse_src.sv */
`default_nettype none
module ddct_pulse_src (
  input wire logic clk_sys,
  output logic eventPin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial eventPin = 1'b0;
  // with the rejector on keep w above two sampling periods, bar glitches
  task automatic edges(input int n, input int w);
    repeat (n) begin
      repeat (w) @(posedge clk_sys);
      eventPin <= ~eventPin;
    end
    repeat (12) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

/* File: testbench/dual_down_counter_timer_bench.sv */
`default_nettype none
module dual_down_counter_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic lowOsc = 1'b0, highOsc = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, tog, serClk, irq0, irq1;
  wire logic evPin;
  int miscompares = 0, n_tests = 0;
  int dv[4] = '{1, 4, 32, 256};
  always #25 clk_sys = ~clk_sys;
  // short rejector period keeps the run brief
  ddct_timer #(.FILT_CYCLES(8)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .lowSpeedOsc(lowOsc), .highSpeedOsc(highOsc),
    .eventInputPin(evPin), .underflowToggleOutput(tog),
    .serialClkOut(serClk), .irqReqT0(irq0), .irqReqT1(irq1)
  );
  ddct_pulse_src src (.clk_sys(clk_sys), .eventPin(evPin));
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ready is looked at mid-cycle so the edge that samples it is race free
  task automatic wt();
    int k;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      miscompares++;
      print_verdict();
    end else @(posedge clk_sys);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wt();
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q | {hresp, 31'h0}, e);
  endtask
  task automatic tick(input int n, input logic hi);
    repeat (2 * n) begin
      repeat (4) @(posedge clk_sys);
      if (hi) highOsc <= ~highOsc;
      else lowOsc <= ~lowOsc;
    end
    repeat (12) @(posedge clk_sys);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rd(ddct_pkg::OFS_CTRL, 32'h0);
    wr(ddct_pkg::OFS_RLD0, 32'h5);
    wr(ddct_pkg::OFS_RLD1, 32'h7);
    for (int c = 0; c < 4; c++) begin
      wr(ddct_pkg::OFS_CTRL, 32'h0);
      wr(ddct_pkg::OFS_PRE, 32'h3);
      rd(ddct_pkg::OFS_CNT0, 32'h5);
      wr(ddct_pkg::OFS_CTRL, 32'h1001 | (32'(c) << 8));
      tick(2 * dv[c], 1'b1);
      rd(ddct_pkg::OFS_CNT0, 32'h3);
    end
    wr(ddct_pkg::OFS_CTRL, 32'h0);
    tick(2, 1'b1);
    rd(ddct_pkg::OFS_CNT0, 32'h3);
    wr(ddct_pkg::OFS_CTRL, 32'h1);
    tick(1, 1'b0);
    rd(ddct_pkg::OFS_CNT0, 32'h2);
    wr(ddct_pkg::OFS_CTRL, 32'h1001);
    tick(2, 1'b0);
    rd(ddct_pkg::OFS_CNT0, 32'h2);
    tick(3, 1'b1);
    rd(ddct_pkg::OFS_CNT0, 32'h5);
    rd(ddct_pkg::OFS_FLAG, 32'h5);
    chk({31'h0, irq0}, 32'h0);
    wr(ddct_pkg::OFS_MASK, 32'h3);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq0}, 32'h1);
    wr(ddct_pkg::OFS_FLAG, 32'h1);
    rd(ddct_pkg::OFS_FLAG, 32'h4);
    chk({31'h0, tog}, 32'h1);
    wr(ddct_pkg::OFS_CTRL, 32'h0);
    wr(ddct_pkg::OFS_PRE, 32'h3);
    wr(ddct_pkg::OFS_CTRL, 32'h134b);
    src.edges(3, 6);
    rd(ddct_pkg::OFS_CNT0, 32'h4);
    rd(ddct_pkg::OFS_CNT1, 32'h7);
    tick(8, 1'b0);
    chk({29'h0, tog, irq1, serClk}, 32'h3);
    wr(ddct_pkg::OFS_CTRL, 32'h131b);
    src.edges(3, 6);
    rd(ddct_pkg::OFS_CNT0, 32'h3);
    wr(ddct_pkg::OFS_CTRL, 32'h133b);
    src.edges(2, 2);
    rd(ddct_pkg::OFS_CNT0, 32'h3);
    src.edges(2, 24);
    rd(ddct_pkg::OFS_CNT0, 32'h2);
    wr(ddct_pkg::OFS_CTRL, 32'h1005);
    tick(3, 1'b1);
    rd(ddct_pkg::OFS_CNT0, 32'h5);
    rd(ddct_pkg::OFS_CNT1, 32'h6);
    print_verdict();
  end
endmodule
`default_nettype wire
